/* verilog/fps_pkg.sv */
// constants and types shared by the fault protection sequencer
// Summary of operation
// - peak limit tripped: fault timer counts up once per 10 ms tick
// - peak limit silent: fault timer counts down once per 10 ms tick
// - timer completes when count reaches eight ticks
// - auto-recovery: completion halts all switching, rail decays by own consumption
// - auto-recovery: supply stop level reached, re-enter startup and resume switching
// - latching: after 80 ms enter latch, stop gate pulses, enable supply clamp
// - winding-short comparator trip shuts the controller down immediately
// - winding-short shutdown latches or auto-recovers like overload protection
// - temperature variants: fault pin below low threshold latches off
// - temperature variants: fault pin over overvoltage threshold latches off with clamp
// - overvoltage or overtemperature latch holds until latch-hold current lost
// - brown-out variants: stop switching while bulk image below threshold
// - after brown-out clears, resume only at supply start level, via soft-start
// - brown-out variants: overvoltage trip latches off until power cycled
// - timer counts up only on peak current comparator trip
// - every restart applies fixed 4 ms soft-start before regulation
package fps_pkg;
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned TICK_TIME_MS = 10;
    localparam int unsigned SOFT_START_TIME_MS = 4;
    localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
    localparam int unsigned SOFT_START_CYCLES = CLK_FREQ_HZ / 1000 * SOFT_START_TIME_MS;
    localparam int unsigned FAULT_TIME_MS = 80;
    localparam int unsigned FAULT_TICKS = FAULT_TIME_MS / TICK_TIME_MS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] FAULT_DONE_COUNT = CNT_W'(FAULT_TICKS);
    localparam logic [CNT_W-1:0] COUNT_RESET = 4'h0;
    typedef enum logic [2:0] {
        FPS_STARTUP,
        FPS_SOFT_START,
        FPS_RUN,
        FPS_HALT,
        FPS_BROWN_OUT,
        FPS_LATCHED
    } fps_state_e;
endpackage

/* verilog/fps_fault_timer.sv */
// up/down overload fault timer with completion flag
`timescale 1ns/1ps
module fps_fault_timer
    import fps_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clear,
    input wire logic enable,
    input wire logic peak_trip,
    output logic [CNT_W-1:0] count,
    output logic done
);
    logic [31:0] div_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire tick = (div_q == TICK_CYC - 1);
    wire at_top = (cnt_q == FAULT_DONE_COUNT);
    wire at_zero = (cnt_q == COUNT_RESET);

    ////////////////////////////////////////////////////////////////
    always_comb begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = COUNT_RESET;
        end else if (enable && tick) begin
            if (peak_trip && !at_top) begin
                cnt_d = cnt_q + 4'h1;
            end else if (!peak_trip && !at_zero) begin
                cnt_d = cnt_q - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_q <= 32'h0;
            cnt_q <= COUNT_RESET;
        end else begin
            div_q <= (clear || tick) ? 32'h0 : div_q + 32'h1;
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
    assign done = at_top;
endmodule

/* verilog/fps_sequencer.sv */
// fault protection sequencer: protection state machine and gate enables
`timescale 1ns/1ps
module fps_sequencer
    import fps_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter int unsigned SOFT_CYC = SOFT_START_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic variant_latching,
    input wire logic variant_brown_out,
    input wire logic peak_limit_comparator,
    input wire logic winding_short_comparator,
    input wire logic fault_pin_low,
    input wire logic over_voltage_trip,
    input wire logic brown_out_comparator,
    input wire logic supply_stop_level,
    input wire logic supply_start_level,
    input wire logic latch_hold_current,
    output logic gate_drive_output,
    output logic soft_start_active,
    output logic supply_latch_clamp_level,
    output logic brown_out_hyst_enable,
    output logic [CNT_W-1:0] fault_count,
    output logic [2:0] protect_state
);
    fps_state_e state_q;
    fps_state_e state_d;
    logic [31:0] ss_q;
    logic [31:0] ss_d;
    logic gate_q;
    logic clamp_q;
    logic hyst_q;
    logic timer_done;

    ////////////////////////////////////////////////////////////////
    // fault decode
    wire running = (state_q == FPS_SOFT_START) || (state_q == FPS_RUN);
    wire ovp_latch = over_voltage_trip;
    wire otp_latch = !variant_brown_out && fault_pin_low;
    wire hard_latch = ovp_latch || otp_latch;
    wire overload = timer_done || winding_short_comparator;
    wire bo_low = variant_brown_out && brown_out_comparator;
    wire ss_done = (ss_q == SOFT_CYC - 1);
    wire timer_clear = (state_q == FPS_STARTUP);

    fps_fault_timer #(
        .TICK_CYC(TICK_CYC)
    ) u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(timer_clear),
        .enable(running),
        .peak_trip(peak_limit_comparator),
        .count(fault_count),
        .done(timer_done)
    );

    ////////////////////////////////////////////////////////////////
    // state machine
    always_comb begin
        state_d = state_q;
        ss_d = 32'h0;
        case (state_q)
            FPS_STARTUP: begin
                if (hard_latch) begin
                    state_d = FPS_LATCHED;
                end else if (supply_start_level && !bo_low) begin
                    state_d = FPS_SOFT_START;
                end
            end
            FPS_SOFT_START, FPS_RUN: begin
                if (state_q == FPS_SOFT_START) begin
                    ss_d = ss_q + 32'h1;
                end
                if (hard_latch) begin
                    state_d = FPS_LATCHED;
                end else if (overload) begin
                    state_d = variant_latching ? FPS_LATCHED : FPS_HALT;
                end else if (bo_low) begin
                    state_d = FPS_BROWN_OUT;
                end else if (state_q == FPS_SOFT_START && ss_done) begin
                    state_d = FPS_RUN;
                end
            end
            FPS_HALT: begin
                if (hard_latch) begin
                    state_d = FPS_LATCHED;
                end else if (supply_stop_level) begin
                    state_d = FPS_STARTUP;
                end
            end
            FPS_BROWN_OUT: begin
                if (hard_latch) begin
                    state_d = FPS_LATCHED;
                end else if (!bo_low) begin
                    state_d = FPS_STARTUP;
                end
            end
            FPS_LATCHED: begin
                if (!latch_hold_current) begin
                    state_d = FPS_STARTUP;
                end
            end
            default: begin
                state_d = FPS_STARTUP;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // registered outputs
    wire gate_d = (state_d == FPS_SOFT_START) || (state_d == FPS_RUN);
    wire clamp_d = (state_d == FPS_LATCHED);
    wire hyst_d = variant_brown_out && brown_out_comparator;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= FPS_STARTUP;
            ss_q <= 32'h0;
            gate_q <= 1'b0;
            clamp_q <= 1'b0;
            hyst_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ss_q <= ss_d;
            gate_q <= gate_d;
            clamp_q <= clamp_d;
            hyst_q <= hyst_d;
        end
    end

    assign gate_drive_output = gate_q;
    assign soft_start_active = (state_q == FPS_SOFT_START);
    assign supply_latch_clamp_level = clamp_q;
    assign brown_out_hyst_enable = hyst_q;
    assign protect_state = state_q;
endmodule

/* test/fps_props.sv */
// assertion checker for the fault protection sequencer
`timescale 1ns/1ps
module fps_props
    import fps_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter int unsigned SOFT_CYC = SOFT_START_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic variant_brown_out,
    input wire logic peak_limit_comparator,
    input wire logic winding_short_comparator,
    input wire logic over_voltage_trip,
    input wire logic brown_out_comparator,
    input wire logic supply_stop_level,
    input wire logic latch_hold_current,
    input wire logic gate_drive_output,
    input wire logic soft_start_active,
    input wire logic supply_latch_clamp_level,
    input wire logic brown_out_hyst_enable,
    input wire logic [CNT_W-1:0] fault_count,
    input wire logic [2:0] protect_state
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_soft_hold;
        soft_start_active [*4];
    endsequence
    a_soft_len: assert property ($rose(soft_start_active) |-> s_soft_hold ##[1:2]
        protect_state == FPS_RUN) else $error("soft start length off");
    a_latch_no_gate: assert property (supply_latch_clamp_level |-> !gate_drive_output)
        else $error("gate on while clamped");
    a_short_stop: assert property (winding_short_comparator |=> !gate_drive_output)
        else $error("gate on after winding short");
    a_ov_latch: assert property (over_voltage_trip && gate_drive_output |=>
        supply_latch_clamp_level) else $error("no latch on overvoltage");
    a_latch_hold: assert property (protect_state == FPS_LATCHED && latch_hold_current |=>
        protect_state == FPS_LATCHED) else $error("latch left early");
    a_bo_stop: assert property (variant_brown_out && brown_out_comparator |=>
        !gate_drive_output && brown_out_hyst_enable) else $error("brown-out not handled");
    a_count_cause: assert property (fault_count > $past(fault_count) |->
        $past(peak_limit_comparator)) else $error("count rose without trip");
    a_done_stop: assert property (fault_count == 4'h8 |-> ##[0:1] !gate_drive_output)
        else $error("gate on after completion");
    a_halt_restart: assert property (protect_state == FPS_HALT && supply_stop_level |=>
        protect_state == FPS_STARTUP ##1 fault_count == 4'h0) else $error("no restart");
endmodule
bind fps_sequencer fps_props #(.TICK_CYC(TICK_CYC), .SOFT_CYC(SOFT_CYC)) u_props (.*);

/* test/fps_rail_model.sv */
// supply rail model: start-up charge, decay when idle, clamp while latched
`timescale 1ns/1ps
module fps_rail_model (
    input wire logic clk_sys,
    input wire logic power_on,
    input wire logic gate_on,
    input wire logic clamp_on,
    output logic stop_lvl,
    output logic start_lvl,
    output logic hold_on
);
    int rail = 0;
    bit up = 1;
    always @(posedge clk_sys) begin
        if (!power_on) begin
            rail <= 0;
            up <= 1;
        end else if (gate_on) begin
            rail <= 12;
            up <= 0;
        end else if (clamp_on) rail <= 7;
        else if (up) rail <= (rail >= 12) ? rail : rail + 1;
        else begin
            rail <= rail - 1;
            up <= rail <= 6;
        end
    end
    assign stop_lvl = rail <= 5;
    assign start_lvl = rail >= 12;
    assign hold_on = power_on && clamp_on;
endmodule

/* test/testbench.sv */
// self-checking bench for the fault protection sequencer
`timescale 1ns/1ps
module testbench;
    import fps_pkg::*;
    logic clk_sys = 0, resetn = 0, variant_latching = 0, variant_brown_out = 0, pwr = 0;
    logic peak_limit_comparator = 0, winding_short_comparator = 0, fault_pin_low = 0;
    logic over_voltage_trip = 0, brown_out_comparator = 0;
    logic supply_stop_level, supply_start_level, latch_hold_current, gate_drive_output;
    logic soft_start_active, supply_latch_clamp_level, brown_out_hyst_enable;
    logic [CNT_W-1:0] fault_count;
    logic [2:0] protect_state;
    int n_fail = 0, checked = 0, t0;
    fps_sequencer #(.TICK_CYC(10), .SOFT_CYC(5)) DUT (.*);
    fps_rail_model rail (.clk_sys(clk_sys), .power_on(pwr), .gate_on(gate_drive_output),
        .clamp_on(supply_latch_clamp_level), .stop_lvl(supply_stop_level),
        .start_lvl(supply_start_level), .hold_on(latch_hold_current));
    initial forever #5 clk_sys = ~clk_sys;
    task chk(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task wait_st(input logic [2:0] s);
        int i;
        for (i = 0; i < 3000 && protect_state !== s; i++) @(negedge clk_sys);
        chk(i < 3000, 1);
        if (i == 3000) end_of_test;
    endtask
    task power(input logic lat, input logic bo);
        @(posedge clk_sys);
        {resetn, pwr, fault_pin_low, over_voltage_trip, brown_out_comparator} <= 5'h0;
        {peak_limit_comparator, variant_latching, variant_brown_out} <= {1'b0, lat, bo};
        repeat (12) @(posedge clk_sys);
        {resetn, pwr} <= 2'h3;
        wait_st(FPS_RUN);
    endtask
    initial begin
        void'($urandom(24162));
        power(0, 0);
        repeat (150) @(posedge clk_sys) peak_limit_comparator <= $urandom % 4 == 0;
        @(negedge clk_sys) chk(protect_state === FPS_RUN, 1);
        power(1, 0);
        @(posedge clk_sys) peak_limit_comparator <= 1;
        repeat (35) @(negedge clk_sys);
        chk(fault_count inside {4'h3, 4'h4}, 1);
        @(posedge clk_sys) peak_limit_comparator <= 0;
        repeat (60) @(negedge clk_sys);
        chk(fault_count === 4'h0, 1);
        @(posedge clk_sys) peak_limit_comparator <= 1;
        t0 = $time / 10;
        wait_st(FPS_LATCHED);
        chk($time / 10 - t0 inside {[71:82]} && fault_count === 4'h8, 1);
        chk({gate_drive_output, supply_latch_clamp_level} === 2'h1, 1);
        repeat (50) @(negedge clk_sys);
        chk(protect_state === FPS_LATCHED, 1);
        @(posedge clk_sys) pwr <= 0;
        wait_st(FPS_STARTUP);
        power(0, 0);
        @(posedge clk_sys) peak_limit_comparator <= 1;
        wait_st(FPS_HALT);
        @(posedge clk_sys) peak_limit_comparator <= 0;
        wait_st(FPS_STARTUP);
        @(negedge clk_sys) chk(fault_count === 4'h0, 1);
        for (int v = 0; v < 2; v++) begin
            power(v[0], 0);
            @(posedge clk_sys) winding_short_comparator <= 1;
            @(posedge clk_sys) winding_short_comparator <= 0;
            wait_st(v ? FPS_LATCHED : FPS_HALT);
        end
        for (int k = 0; k < 3; k++) begin
            power(0, k == 2);
            @(posedge clk_sys) {fault_pin_low, over_voltage_trip} <= {k == 0, k != 0};
            wait_st(FPS_LATCHED);
            chk(supply_latch_clamp_level, 1);
        end
        power(0, 1);
        @(posedge clk_sys) brown_out_comparator <= 1;
        wait_st(FPS_BROWN_OUT);
        chk({gate_drive_output, brown_out_hyst_enable} === 2'h1, 1);
        @(posedge clk_sys) brown_out_comparator <= 0;
        wait_st(FPS_SOFT_START);
        end_of_test;
    end
endmodule
